// >>> core/sdram_cmd_pkg.sv
// Purpose: Shared constants and types for the bank command core.
// Assumes: core_clk at 100 MHz; one data beat per core clock.
// Notes: Precharge and refresh counts derive from times in their own units.
package sdram_cmd_pkg;
  localparam int NUM_BANKS = 8;
  localparam int BANK_W = 3;
  localparam int ADDR_PIN_W = 16;
  localparam int ROW_W = 16;
  localparam int DATA_W = 16;
  localparam int BYTES = DATA_W / 8;
  localparam int CAL_CODE_W = 6;
  localparam int AUTO_PRE_BIT = 10;
  localparam int CHOP_BIT = 12;
  localparam int BEAT_W = 3;
  localparam logic [BEAT_W-1:0] LAST_BEAT_FULL = 3'h7;
  localparam logic [BEAT_W-1:0] LAST_BEAT_CHOP = 3'h3;
  localparam int CLK_PERIOD_PS = 10000;
  localparam int ROW_PRECHARGE_TIME_PS = 13750;
  localparam int ROW_PRECHARGE_CYCLES =
    (ROW_PRECHARGE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PRE_CNT_W = $clog2(ROW_PRECHARGE_CYCLES + 1);
  localparam int REFRESH_CYCLE_TIME_NS = 160;
  localparam int REFRESH_CYCLES =
    (REFRESH_CYCLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int REF_CNT_W = $clog2(REFRESH_CYCLES + 1);
  localparam int SHORT_CAL_CYCLES = 64;
  localparam int CAL_CNT_W = $clog2(SHORT_CAL_CYCLES + 1);
  localparam int LAT_W = 5;

  typedef enum logic [1:0] {bank_idle, bank_active, bank_precharging} bank_state_type;
  typedef enum logic [2:0] {
    cmd_nop, cmd_act, cmd_rd, cmd_wr, cmd_pre, cmd_ref, cmd_short_impedance_calibration, cmd_other
  } cmd_type;
  typedef enum logic [1:0] {burst_none, burst_wait, burst_run} burst_state_type;
endpackage : sdram_cmd_pkg

// >>> core/bank_ctrl_if.sv
// Purpose: Carries bank open/close requests and per-bank state.
// Assumes: Single core_clk domain.
// Notes: Requests are one-cycle pulses.
`timescale 1ns/1ps
interface bank_ctrl_if;
  import sdram_cmd_pkg::*;
  logic act;
  logic pre;
  logic pre_all;
  logic ap_close;
  logic [BANK_W-1:0] bank;
  logic [BANK_W-1:0] ap_bank;
  logic [ROW_W-1:0] row;
  logic [NUM_BANKS-1:0] bank_open;
  logic [NUM_BANKS-1:0] bank_is_idle;
  logic [ROW_W-1:0] open_row [NUM_BANKS];

  modport core (
    output act, pre, pre_all, ap_close, bank, ap_bank, row,
    input bank_open, bank_is_idle, open_row
  );
  modport tracker (
    input act, pre, pre_all, ap_close, bank, ap_bank, row,
    output bank_open, bank_is_idle, open_row
  );
endinterface : bank_ctrl_if

// >>> core/bank_tracker.sv
// Purpose: Per-bank row state and precharge timing.
// Assumes: Core only activates idle banks.
// Notes: Precharge to an idle bank has no effect.
`timescale 1ns/1ps
module bank_tracker
  import sdram_cmd_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Bank requests and state
  bank_ctrl_if.tracker ctrl
);

  // ----------------------------------------
  // Bank state per bank
  // ----------------------------------------
  for (genvar g = 0; g < NUM_BANKS; g++) begin : g_bank
    bank_state_type state_q;
    logic [PRE_CNT_W-1:0] timer_q;
    logic [ROW_W-1:0] row_q;
    logic pre_hit;
    logic act_hit;

    assign pre_hit = (ctrl.pre && (ctrl.pre_all || ctrl.bank == BANK_W'(g))) ||
                     (ctrl.ap_close && ctrl.ap_bank == BANK_W'(g));
    assign act_hit = ctrl.act && ctrl.bank == BANK_W'(g);

    always_ff @(posedge core_clk) begin
      if (rst) begin
        state_q <= bank_idle;
        timer_q <= '0;
        row_q <= '0;
      end else begin
        unique case (state_q)
          bank_idle: begin
            if (act_hit) begin
              state_q <= bank_active;
              row_q <= ctrl.row;
            end
          end
          bank_active: begin
            if (pre_hit) begin
              state_q <= bank_precharging;
              timer_q <= PRE_CNT_W'(ROW_PRECHARGE_CYCLES - 1);
            end
          end
          bank_precharging: begin
            if (pre_hit) begin
              timer_q <= PRE_CNT_W'(ROW_PRECHARGE_CYCLES - 1);
            end else if (timer_q == '0) begin
              state_q <= bank_idle;
            end else begin
              timer_q <= timer_q - 1'b1;
            end
          end
        endcase
      end
    end

    assign ctrl.bank_open[g] = (state_q == bank_active);
    assign ctrl.bank_is_idle[g] = (state_q == bank_idle);
    assign ctrl.open_row[g] = row_q;
  end

endmodule : bank_tracker

// >>> core/sdram_bank_command_core.sv
// Purpose: Command decode, burst engine, refresh and calibration core.
// Assumes: Command pins and data come from logic on core_clk.
// Notes: Illegal commands are dropped and flagged on protocol_error.
`timescale 1ns/1ps
module sdram_bank_command_core
  import sdram_cmd_pkg::*;
#(
  parameter int COL_W = 4,
  parameter int ROW_LOW_W = 2,
  parameter logic [LAT_W-1:0] READ_LATENCY = 5'h05,
  parameter logic [LAT_W-1:0] WRITE_LATENCY = 5'h04
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Command and address
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BANK_W-1:0] ba,
  input wire logic [ADDR_PIN_W-1:0] addr,
  // Burst configuration
  input wire logic otf_burst_enable,
  input wire logic fixed_chop_select,
  input wire logic interleaved_burst,
  // Write data
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [BYTES-1:0] write_byte_mask,
  output logic wr_beat_take,
  // Read data
  output wire logic [DATA_W-1:0] rd_data,
  output logic rd_valid,
  // Calibration
  input wire logic [CAL_CODE_W-1:0] cal_target,
  output logic [CAL_CODE_W-1:0] drive_code,
  output logic cal_busy,
  // Status
  output logic refresh_busy,
  output logic [ROW_W-1:0] refresh_row,
  output logic [NUM_BANKS-1:0] bank_open,
  output logic burst_busy,
  output logic protocol_error
);

  localparam int MEM_ADDR_W = BANK_W + ROW_LOW_W + COL_W;
  localparam int MEM_DEPTH = 2 ** MEM_ADDR_W;

  bank_ctrl_if bank_if ();

  bank_tracker u_bank_tracker (
    .core_clk(core_clk),
    .rst(rst),
    .ctrl(bank_if.tracker)
  );

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  logic cke_prev_q;
  cmd_type cmd;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cke_prev_q <= 1'b0;
    end else begin
      cke_prev_q <= cke;
    end
  end

  always_comb begin
    cmd = cmd_nop;
    if (cke_prev_q && cke && !cs_n) begin
      unique case ({ras_n, cas_n, we_n})
        3'h3: cmd = cmd_act;
        3'h5: cmd = cmd_rd;
        3'h4: cmd = cmd_wr;
        3'h2: cmd = cmd_pre;
        3'h1: cmd = cmd_ref;
        3'h6: cmd = addr[AUTO_PRE_BIT] ? cmd_other : cmd_short_impedance_calibration;
        3'h7: cmd = cmd_nop;
        default: cmd = cmd_other;
      endcase
    end
  end

  // ----------------------------------------
  // Command checks
  // ----------------------------------------
  logic rw_cmd;
  logic rw_ok;
  logic act_ok;
  logic ref_ok;
  logic pre_ok;
  logic zq_ok;
  logic busy_block;
  logic [BEAT_W-1:0] last_beat;
  burst_state_type burst_q;
  logic [REF_CNT_W-1:0] ref_cnt_q;
  logic [CAL_CNT_W-1:0] cal_cnt_q;

  assign busy_block = (ref_cnt_q != '0);
  assign rw_cmd = (cmd == cmd_rd) || (cmd == cmd_wr);
  // Other banks stay reachable while one auto precharges
  assign rw_ok = rw_cmd && !busy_block && bank_if.bank_open[ba] &&
                 (burst_q == burst_none);
  assign act_ok = (cmd == cmd_act) && !busy_block && bank_if.bank_is_idle[ba];
  assign pre_ok = (cmd == cmd_pre) && !busy_block;
  assign ref_ok = (cmd == cmd_ref) && !busy_block && (&bank_if.bank_is_idle);
  assign zq_ok = (cmd == cmd_short_impedance_calibration) && !busy_block && (cal_cnt_q == '0);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      protocol_error <= 1'b0;
    end else begin
      protocol_error <= (rw_cmd && !rw_ok) || ((cmd == cmd_act) && !act_ok) ||
                        ((cmd == cmd_pre) && !pre_ok) || ((cmd == cmd_ref) && !ref_ok) ||
                        ((cmd == cmd_short_impedance_calibration) && !zq_ok) || (cmd == cmd_other);
    end
  end

  // ----------------------------------------
  // Refresh
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ref_cnt_q <= '0;
      refresh_row <= '0;
    end else if (ref_ok) begin
      ref_cnt_q <= REF_CNT_W'(REFRESH_CYCLES);
      refresh_row <= refresh_row + 1'b1;
    end else if (ref_cnt_q != '0) begin
      ref_cnt_q <= ref_cnt_q - 1'b1;
    end
  end

  assign refresh_busy = (ref_cnt_q != '0);

  // ----------------------------------------
  // Short calibration
  // ----------------------------------------
  logic [CAL_CODE_W-1:0] cal_work_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cal_cnt_q <= '0;
      cal_work_q <= '0;
      drive_code <= '0;
    end else if (zq_ok) begin
      cal_cnt_q <= CAL_CNT_W'(SHORT_CAL_CYCLES);
      cal_work_q <= drive_code;
    end else if (cal_cnt_q != '0) begin
      cal_cnt_q <= cal_cnt_q - 1'b1;
      if (cal_work_q < cal_target) begin
        cal_work_q <= cal_work_q + 1'b1;
      end else if (cal_work_q > cal_target) begin
        cal_work_q <= cal_work_q - 1'b1;
      end
      if (cal_cnt_q == CAL_CNT_W'(1)) begin
        drive_code <= cal_work_q;
      end
    end
  end

  assign cal_busy = (cal_cnt_q != '0);

  // ----------------------------------------
  // Bank requests
  // ----------------------------------------
  logic ap_pulse;
  logic [BANK_W-1:0] burst_bank_q;

  assign bank_if.act = act_ok;
  assign bank_if.pre = pre_ok;
  assign bank_if.pre_all = addr[AUTO_PRE_BIT];
  assign bank_if.bank = ba;
  assign bank_if.row = addr;
  assign bank_if.ap_close = ap_pulse;
  assign bank_if.ap_bank = burst_bank_q;
  assign bank_open = bank_if.bank_open;

  // ----------------------------------------
  // Burst engine
  // ----------------------------------------
  logic burst_write_q;
  logic [ROW_LOW_W-1:0] burst_row_q;
  logic [COL_W-1:0] burst_col_q;
  logic burst_chop_q;
  logic burst_ilv_q;
  logic burst_ap_q;
  logic [LAT_W-1:0] lat_cnt_q;
  logic [BEAT_W-1:0] beat_q;
  logic beat_now;

  function automatic logic [BEAT_W-1:0] beat_col(
    input logic [BEAT_W-1:0] start,
    input logic [BEAT_W-1:0] idx,
    input logic ilv
  );
    logic [1:0] low;
    low = start[1:0] + idx[1:0];
    if (ilv) begin
      beat_col = start ^ idx;
    end else begin
      beat_col = {start[2] ^ idx[2], low};
    end
  endfunction : beat_col

  assign last_beat = burst_chop_q ? LAST_BEAT_CHOP : LAST_BEAT_FULL;
  assign beat_now = (burst_q == burst_run);
  assign ap_pulse = beat_now && (beat_q == last_beat) && burst_ap_q;
  assign burst_busy = (burst_q != burst_none);
  assign wr_beat_take = beat_now && burst_write_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      burst_q <= burst_none;
      burst_write_q <= 1'b0;
      burst_bank_q <= '0;
      burst_row_q <= '0;
      burst_col_q <= '0;
      burst_chop_q <= 1'b0;
      burst_ilv_q <= 1'b0;
      burst_ap_q <= 1'b0;
      lat_cnt_q <= '0;
      beat_q <= '0;
    end else begin
      unique case (burst_q)
        burst_none: begin
          if (rw_ok) begin
            burst_q <= burst_wait;
            burst_write_q <= (cmd == cmd_wr);
            burst_bank_q <= ba;
            burst_row_q <= bank_if.open_row[ba][ROW_LOW_W-1:0];
            burst_col_q <= addr[COL_W-1:0];
            burst_chop_q <= otf_burst_enable ? !addr[CHOP_BIT] : fixed_chop_select;
            burst_ilv_q <= interleaved_burst;
            burst_ap_q <= addr[AUTO_PRE_BIT];
            lat_cnt_q <= ((cmd == cmd_wr) ? WRITE_LATENCY : READ_LATENCY) - 1'b1;
            beat_q <= '0;
          end
        end
        burst_wait: begin
          if (lat_cnt_q == '0) begin
            burst_q <= burst_run;
          end else begin
            lat_cnt_q <= lat_cnt_q - 1'b1;
          end
        end
        burst_run: begin
          if (beat_q == last_beat) begin
            burst_q <= burst_none;
          end else begin
            beat_q <= beat_q + 1'b1;
          end
        end
        default: burst_q <= burst_none;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= beat_now && !burst_write_q;
    end
  end

  // ----------------------------------------
  // Storage, one lane per byte
  // ----------------------------------------
  logic [MEM_ADDR_W-1:0] mem_addr;
  logic [BEAT_W-1:0] cur_col;

  assign cur_col = beat_col(burst_col_q[BEAT_W-1:0], beat_q, burst_ilv_q);
  assign mem_addr = {burst_bank_q, burst_row_q, burst_col_q[COL_W-1:BEAT_W], cur_col};

  for (genvar b = 0; b < BYTES; b++) begin : g_lane
    logic [7:0] lane_mem [MEM_DEPTH];
    logic [7:0] lane_rd_q;

    always_ff @(posedge core_clk) begin
      if (wr_beat_take && !write_byte_mask[b]) begin
        lane_mem[mem_addr] <= wr_data[b*8 +: 8];
      end
    end

    always_ff @(posedge core_clk) begin
      if (rst) begin
        lane_rd_q <= '0;
      end else if (beat_now && !burst_write_q) begin
        lane_rd_q <= lane_mem[mem_addr];
      end
    end

    assign rd_data[b*8 +: 8] = lane_rd_q;
  end

endmodule : sdram_bank_command_core

// >>> testbench/mc_model.sv
// Purpose: Controller model driving command pins and write beats.
// Assumes: One command at a time through issue.
// Notes: Deselected ba and addr show inverted last values; ras_n, cas_n and we_n hold theirs.
`timescale 1ns/1ps
module mc_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Write beat control
  input wire logic wr_beat_take,
  input wire logic mask_on,
  input wire logic [15:0] data_base,
  // Command pins
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [2:0] ba,
  output logic [15:0] addr,
  // Write data
  output logic [15:0] wr_data,
  output logic [1:0] write_byte_mask
);
  logic [2:0] cnt_q;
  logic [15:0] word;

  initial begin
    cke = 1'b1;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    ba = 3'h0;
    addr = 16'h0000;
  end

  task automatic issue(input logic [2:0] c, input logic [2:0] b, input logic [15:0] a);
    @(negedge core_clk);
    cs_n = 1'b0;
    {ras_n, cas_n, we_n} = c;
    ba = b;
    addr = a;
    @(negedge core_clk);
    cs_n = 1'b1;
    ba = ~b;
    addr = ~a;
  endtask : issue

  // Beat counter restarts at each command
  always_ff @(posedge core_clk) begin
    if (rst) cnt_q <= 3'h0;
    else if (wr_beat_take) cnt_q <= cnt_q + 3'h1;
    else if (!cs_n) cnt_q <= 3'h0;
  end

  assign word = data_base + {13'h0, cnt_q};
  assign wr_data = wr_beat_take ? word : ~word;
  assign write_byte_mask = mask_on ? {cnt_q[0], ~cnt_q[0]} : 2'h0;
endmodule : mc_model

// >>> testbench/sdram_core_monitor.sv
// Purpose: Port checks for the bank command core.
// Assumes: Latencies handed on by bind.
// Notes: Acceptance decoded from pins and status.
`timescale 1ns/1ps
module sdram_core_monitor #(
  parameter logic [4:0] READ_LATENCY = 5'h05,
  parameter logic [4:0] WRITE_LATENCY = 5'h04
) (
  // Clock and reset
  input logic core_clk,
  input logic rst,
  // Command pins
  input logic cke,
  input logic cs_n,
  input logic ras_n,
  input logic cas_n,
  input logic we_n,
  input logic [2:0] ba,
  input logic [15:0] addr,
  // Status
  input logic rd_valid,
  input logic wr_beat_take,
  input logic [5:0] drive_code,
  input logic cal_busy,
  input logic refresh_busy,
  input logic [15:0] refresh_row,
  input logic [7:0] bank_open,
  input logic burst_busy,
  input logic protocol_error
);
  localparam int RD_D = int'(READ_LATENCY) + 1;
  localparam int WR_D = int'(WRITE_LATENCY) + 1;
  logic cke_q;
  logic [2:0] ba_q;
  logic [4:0] rc_q;
  logic tk;
  logic [2:0] cmd;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  assign cmd = {ras_n, cas_n, we_n};
  assign tk = cke && cke_q && !cs_n;

  always_ff @(posedge core_clk) begin
    cke_q <= rst ? 1'b0 : cke;
  end
  always_ff @(posedge core_clk) begin
    ba_q <= ba;
  end
  always_ff @(posedge core_clk) begin
    rc_q <= (rst || !refresh_busy) ? 5'h00 : rc_q + 5'h01;
  end

  a_read_burst_start: assert property (tk && cmd == 3'h5 && !burst_busy && !refresh_busy
    && bank_open[ba] |=> burst_busy ##RD_D rd_valid) else $error("read start late");
  a_write_beat_start: assert property (tk && cmd == 3'h4 && !burst_busy && !refresh_busy
    && bank_open[ba] |-> ##WR_D wr_beat_take) else $error("write beats late");
  a_burst_length: assert property ($rose(rd_valid) |-> rd_valid[*4] ##1
    (!rd_valid or (rd_valid[*4] ##1 !rd_valid))) else $error("bad burst length");
  a_act_opens_bank: assert property (tk && cmd == 3'h3 ##1 !protocol_error
    |-> bank_open[ba_q]) else $error("row not opened");
  a_pre_one_bank: assert property (tk && cmd == 3'h2 && !addr[10] && !refresh_busy
    |=> !bank_open[ba_q]) else $error("bank not closed");
  a_pre_all_banks: assert property (tk && cmd == 3'h2 && addr[10] && !refresh_busy
    |=> bank_open == 8'h00) else $error("banks not closed");
  a_refresh_row_step: assert property ($rose(refresh_busy)
    |-> refresh_row == $past(refresh_row) + 16'h0001) else $error("row not stepped");
  a_refresh_span: assert property ($fell(refresh_busy) |-> rc_q == 5'h10)
    else $error("refresh span wrong");
  a_busy_refuses: assert property (refresh_busy && tk && cmd != 3'h7 |=> protocol_error)
    else $error("command taken in refresh");
  a_cal_window: assert property ($rose(cal_busy) |-> ##63 cal_busy ##1 !cal_busy)
    else $error("calibration window wrong");
  a_code_held: assert property (cal_busy && $past(cal_busy) |-> $stable(drive_code))
    else $error("code moved early");

  c_read: cover property ($rose(rd_valid));
  c_refresh: cover property ($rose(refresh_busy));
  c_refused: cover property (protocol_error);
endmodule : sdram_core_monitor

bind sdram_bank_command_core sdram_core_monitor #(
  .READ_LATENCY(READ_LATENCY),
  .WRITE_LATENCY(WRITE_LATENCY)
) mon (.core_clk, .rst, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .rd_valid,
  .wr_beat_take, .drive_code, .cal_busy, .refresh_busy, .refresh_row, .bank_open,
  .burst_busy, .protocol_error);

// >>> testbench/sdram_bank_command_core_tb.sv
// Purpose: Self-checking bench for the bank command core.
// Assumes: Default latencies, commands from the controller model.
// Notes: One burst written, then masked, then read in all orders.
`timescale 1ns/1ps
module sdram_bank_command_core_tb;
  typedef struct {logic [2:0] s; logic ilv; logic otf; logic sel; int n; logic [31:0] cols;}
    row_type;
  logic core_clk, rst, cke, cs_n, ras_n, cas_n, we_n;
  logic [2:0] ba;
  logic [15:0] addr, wr_data, rd_data, refresh_row, data_base, r0;
  logic [1:0] write_byte_mask;
  logic otf_burst_enable, fixed_chop_select, interleaved_burst, mask_on;
  logic wr_beat_take, rd_valid, cal_busy, refresh_busy, burst_busy, protocol_error;
  logic [5:0] cal_target, drive_code;
  logic [7:0] bank_open;
  int failures = 0;
  int samples_checked = 0;
  row_type rows [6] = '{'{3'h5, 1'b0, 1'b1, 1'b1, 8, 32'h56741230},
    '{3'h5, 1'b1, 1'b1, 1'b1, 8, 32'h54761032}, '{3'h2, 1'b0, 1'b1, 1'b0, 4, 32'h23010000},
    '{3'h6, 1'b1, 1'b1, 1'b0, 4, 32'h67450000}, '{3'h3, 1'b0, 1'b0, 1'b1, 4, 32'h30120000},
    '{3'h0, 1'b0, 1'b0, 1'b0, 8, 32'h01234567}};

  sdram_bank_command_core uut (.*);
  mc_model mc (.*);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic final_report;
    if (failures == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic logic [15:0] exp_w(input logic [2:0] c);
    return c[0] ? {8'h5a, 8'hf0 + {5'h0, c}} : {8'hc3, 5'h0, c};
  endfunction : exp_w

  task automatic wait_idle;
    for (int k = 0; k < 40 && burst_busy !== 1'b0; k++) @(negedge core_clk);
    chk("burst_busy", 16'h0, {15'h0, burst_busy});
  endtask : wait_idle

  task automatic rd_chk(input logic [2:0] b, input logic [15:0] a, input int n,
    input logic [31:0] cols);
    mc.issue(3'h5, b, a);
    for (int k = 0; k < 20 && rd_valid !== 1'b1; k++) @(negedge core_clk);
    chk("rd_valid", 16'h1, {15'h0, rd_valid});
    for (int i = 0; i < n; i++) begin
      chk("rd_data", exp_w(cols[28-4*i +: 3]), rd_data);
      @(negedge core_clk);
    end
    chk("rd_valid", 16'h0, {15'h0, rd_valid});
    wait_idle();
  endtask : rd_chk

  initial begin
    #60000;
    failures++;
    final_report();
  end

  initial begin
    rst = 1'b1;
    otf_burst_enable = 1'b1;
    fixed_chop_select = 1'b0;
    interleaved_burst = 1'b0;
    cal_target = 6'h05;
    mask_on = 1'b0;
    data_base = 16'h5a00;
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    repeat (2) @(negedge core_clk);
    mc.issue(3'h3, 3'h2, 16'h0003);
    chk("bank_open", 16'h0004, {8'h0, bank_open});
    mc.issue(3'h4, 3'h2, 16'h1000);
    wait_idle();
    mask_on = 1'b1;
    data_base = 16'hc3f0;
    mc.issue(3'h4, 3'h2, 16'h1000);
    wait_idle();
    mask_on = 1'b0;
    // ----------------------------------------
    // Burst orders and lengths
    // ----------------------------------------
    foreach (rows[i]) begin
      interleaved_burst = rows[i].ilv;
      otf_burst_enable = rows[i].otf;
      fixed_chop_select = !rows[i].otf && rows[i].sel;
      rd_chk(3'h2, {3'h0, rows[i].sel, 9'h0, rows[i].s}, rows[i].n, rows[i].cols);
    end
    otf_burst_enable = 1'b1;
    fixed_chop_select = 1'b0;
    interleaved_burst = 1'b0;
    // ----------------------------------------
    // Auto close, precharge, refresh, calibration
    // ----------------------------------------
    mc.issue(3'h3, 3'h5, 16'h0001);
    rd_chk(3'h2, 16'h1400, 8, 32'h01234567);
    mc.issue(3'h5, 3'h5, 16'h1000);
    repeat (6) @(negedge core_clk);
    chk("rd_valid", 16'h1, {15'h0, rd_valid});
    wait_idle();
    chk("bank_open", 16'h0020, {8'h0, bank_open});
    mc.issue(3'h5, 3'h2, 16'h1000);
    chk("protocol_error", 16'h1, {15'h0, protocol_error});
    mc.issue(3'h3, 3'h5, 16'h0002);
    chk("protocol_error", 16'h1, {15'h0, protocol_error});
    mc.issue(3'h3, 3'h1, 16'h0001);
    mc.issue(3'h2, 3'h5, 16'h0000);
    chk("bank_open", 16'h0002, {8'h0, bank_open});
    mc.issue(3'h2, 3'h3, 16'h0000);
    chk("protocol_error", 16'h0, {15'h0, protocol_error});
    mc.issue(3'h2, 3'h5, 16'h0400);
    chk("bank_open", 16'h0000, {8'h0, bank_open});
    repeat (3) @(negedge core_clk);
    r0 = refresh_row;
    mc.issue(3'h1, 3'h0, 16'hffff);
    chk("refresh_row", r0 + 16'h1, refresh_row);
    mc.issue(3'h3, 3'h1, 16'h0001);
    chk("protocol_error", 16'h1, {15'h0, protocol_error});
    for (int k = 0; k < 30 && refresh_busy !== 1'b0; k++) @(negedge core_clk);
    chk("refresh_busy", 16'h0, {15'h0, refresh_busy});
    mc.issue(3'h6, 3'h0, 16'h0000);
    chk("cal_busy", 16'h1, {15'h0, cal_busy});
    for (int k = 0; k < 80 && cal_busy !== 1'b0; k++) @(negedge core_clk);
    chk("cal_busy", 16'h0, {15'h0, cal_busy});
    chk("drive_code", 16'h0005, {10'h0, drive_code});
    // ----------------------------------------
    // Clock enable gating and precharge restart
    // ----------------------------------------
    mc.cke = 1'b0;
    mc.issue(3'h3, 3'h6, 16'h0001);
    fork
      mc.issue(3'h3, 3'h6, 16'h0001);
      begin
        @(negedge core_clk);
        mc.cke = 1'b1;
      end
    join
    chk("bank_open", 16'h0000, {8'h0, bank_open});
    chk("protocol_error", 16'h0, {15'h0, protocol_error});
    mc.issue(3'h3, 3'h4, 16'h0001);
    mc.issue(3'h2, 3'h4, 16'h0000);
    mc.issue(3'h2, 3'h4, 16'h0000);
    mc.issue(3'h3, 3'h4, 16'h0001);
    chk("protocol_error", 16'h1, {15'h0, protocol_error});
    mc.issue(3'h3, 3'h4, 16'h0001);
    chk("bank_open", 16'h0010, {8'h0, bank_open});
    mc.issue(3'h3, 3'h1, 16'h0001);
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    chk("bank_open", 16'h0000, {8'h0, bank_open});
    chk("drive_code", 16'h0000, {10'h0, drive_code});
    rst = 1'b0;
    final_report();
  end
endmodule : sdram_bank_command_core_tb
